// file: common/ddc_pkg.sv
/*
  ddc_pkg: shared constants of the dual band down converter,
  register map, field positions, reset values, trig table.
  Assumes nothing of its surroundings.
*/
`default_nettype none
package ddc_pkg;
  localparam int SAMPLE_W     = 14;
  localparam int OUT_W        = 16;
  localparam int NCO_W        = 32;
  localparam int TRIG_W       = 13;
  localparam int NUM_PATHS    = 2;
  localparam int MAX_LOG2_DEC = 5;
  localparam int ADDR_W       = 8;

  localparam logic [7:0] ADDR_CTRL    = 8'h00;
  localparam logic [7:0] ADDR_NCO_A   = 8'h04;
  localparam logic [7:0] ADDR_NCO_B   = 8'h08;
  localparam logic [7:0] ADDR_RESTART = 8'h0C;
  localparam logic [7:0] ADDR_STATUS  = 8'h10;
  localparam logic [7:0] ADDR_ACT_A   = 8'h14;
  localparam logic [7:0] ADDR_ACT_B   = 8'h18;

  localparam int CTRL_EN        = 0;
  localparam int CTRL_REAL      = 1;
  localparam int CTRL_DEC_LSB   = 2;
  localparam int CTRL_DEC_W     = 3;
  localparam int CTRL_GAIN      = 5;
  localparam int CTRL_FS4       = 6;
  localparam int CTRL_DUAL      = 7;
  localparam int CTRL_INV_LSB   = 8;
  localparam int CTRL_ALIGN_PIN = 10;

  localparam int RESTART_MIXER = 0;
  localparam int RESTART_ALIGN = 1;

  localparam int STATUS_ACTIVE     = 0;
  localparam int STATUS_ALIGN_SEEN = 1;
  localparam int STATUS_PDN        = 2;

  localparam logic [31:0] CTRL_RST = 32'h0000_0000;
  localparam logic [31:0] NCO_RST  = 32'h0000_0000;

  localparam logic [2:0] DEC_SEL_MAX = 3'h4;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // sqrt(2) as 181/128
  localparam logic [8:0] REAL_GAIN_MUL   = 9'h0B5;
  localparam int         REAL_GAIN_SHIFT = 7;

  // quarter sine at half-step offsets, full scale 2047
  localparam logic [15:0][11:0] SIN_TBL = {
    12'h7FD, 12'h7E9, 12'h7C2, 12'h787,
    12'h73A, 12'h6DC, 12'h66C, 12'h5ED,
    12'h55F, 12'h4C3, 12'h41C, 12'h36B,
    12'h2B2, 12'h1F1, 12'h12C, 12'h064};
endpackage
`default_nettype wire

// file: src/ddc_nco.sv
/*
  ddc_nco: phase accumulator with cosine and sine lookup.
  Assumes load_i is a one-cycle pulse in the ref_clk_i domain.
*/
`timescale 1ns/1ps
`default_nettype none
module ddc_nco #(
  parameter int FREQ_W = ddc_pkg::NCO_W
) (
  input  wire logic                             ref_clk_i,
  input  wire logic                             rst_i,
  input  wire logic                             load_i,
  input  wire logic [FREQ_W-1:0]                freq_i,
  output logic signed [ddc_pkg::TRIG_W-1:0]     cos_o,
  output logic signed [ddc_pkg::TRIG_W-1:0]     sin_o,
  output logic        [FREQ_W-1:0]              active_freq_o
);
  logic [FREQ_W-1:0] phase;

  if (FREQ_W < 6) begin : g_chk
    $error("ddc_nco: FREQ_W too small");
  end

  function automatic logic signed [ddc_pkg::TRIG_W-1:0] trig(input logic [1:0] q, input logic [3:0] idx);
    logic [11:0] mag;
    mag  = q[0] ? ddc_pkg::SIN_TBL[4'hF - idx] : ddc_pkg::SIN_TBL[idx];
    trig = q[1] ? -$signed({1'b0, mag}) : $signed({1'b0, mag});
  endfunction

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      phase         <= '0;
      active_freq_o <= FREQ_W'(ddc_pkg::NCO_RST);
    end else if (load_i) begin
      phase         <= '0;
      active_freq_o <= freq_i;
    end else begin
      phase <= phase + active_freq_o;
    end
  end

  // signed word wraps, so the span is -fs/2 to +fs/2
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      cos_o <= '0;
      sin_o <= '0;
    end else begin
      cos_o <= trig(phase[FREQ_W-1 -: 2] + 2'h1, phase[FREQ_W-3 -: 4]);
      sin_o <= trig(phase[FREQ_W-1 -: 2], phase[FREQ_W-3 -: 4]);
    end
  end
endmodule
`default_nettype wire

// file: src/ddc_decim.sv
/*
  ddc_decim: integrate and dump decimator for an I/Q pair.
  Assumes one input pair every clock; clear_i restarts the divider.
*/
`timescale 1ns/1ps
`default_nettype none
module ddc_decim #(
  parameter int W        = ddc_pkg::OUT_W,
  parameter int MAX_LOG2 = ddc_pkg::MAX_LOG2_DEC
) (
  input  wire logic                ref_clk_i,
  input  wire logic                rst_i,
  input  wire logic                clear_i,
  input  wire logic [2:0]          log2n_i,
  input  wire logic signed [W-1:0] in_i,
  input  wire logic signed [W-1:0] in_q,
  output logic signed [W-1:0]      out_i_o,
  output logic signed [W-1:0]      out_q_o,
  output logic                     out_valid_o
);
  localparam int AW = W + MAX_LOG2;
  logic        [MAX_LOG2-1:0] count;
  logic        [MAX_LOG2-1:0] last;
  logic signed [AW-1:0]       acc_i;
  logic signed [AW-1:0]       acc_q;
  logic signed [AW-1:0]       sum_i;
  logic signed [AW-1:0]       sum_q;

  if (MAX_LOG2 < 1 || MAX_LOG2 > 7) begin : g_chk
    $error("ddc_decim: MAX_LOG2 out of range");
  end

  assign last  = MAX_LOG2'((1 << log2n_i) - 1);
  assign sum_i = acc_i + AW'(in_i);
  assign sum_q = acc_q + AW'(in_q);

  // boxcar only: cheap, but aliases far more than a proper fir would
  always_ff @(posedge ref_clk_i) begin
    if (rst_i || clear_i) begin
      count       <= '0;
      acc_i       <= '0;
      acc_q       <= '0;
      out_i_o     <= '0;
      out_q_o     <= '0;
      out_valid_o <= 1'b0;
    end else if (count == last) begin
      count       <= '0;
      acc_i       <= '0;
      acc_q       <= '0;
      out_i_o     <= W'(sum_i >>> log2n_i);
      out_q_o     <= W'(sum_q >>> log2n_i);
      out_valid_o <= 1'b1;
    end else begin
      count       <= count + 1'b1;
      acc_i       <= sum_i;
      acc_q       <= sum_q;
      out_valid_o <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// file: src/ddc_top.sv
/*
  ddc_top: dual band digital down converter between the converter
  core and the output formatter, with an axi4-lite register slave.
  Assumes one 14-bit sample per ref_clk_i edge, inputs synchronous.
*/
`timescale 1ns/1ps
`default_nettype none
module ddc_top #(
  parameter int SAMPLE_W = ddc_pkg::SAMPLE_W,
  parameter int OUT_W    = ddc_pkg::OUT_W
) (
  input  wire logic                      ref_clk_i,
  input  wire logic                      rst_i,
  input  wire logic [SAMPLE_W-1:0]       sample_i,
  input  wire logic                      powerdown_align_pin_i,
  output logic                           powerdown_o,
  output logic [OUT_W-1:0]               chan_a_i_o,
  output logic [OUT_W-1:0]               chan_a_q_o,
  output logic                           chan_a_valid_o,
  output logic                           chan_a_real_o,
  output logic [OUT_W-1:0]               chan_b_lanes_i_o,
  output logic [OUT_W-1:0]               chan_b_lanes_q_o,
  output logic                           chan_b_lanes_valid_o,
  output logic                           chan_b_lanes_real_o,
  input  wire logic [ddc_pkg::ADDR_W-1:0] s_axi_awaddr_i,
  input  wire logic                      s_axi_awvalid_i,
  output logic                           s_axi_awready_o,
  input  wire logic [31:0]               s_axi_wdata_i,
  input  wire logic [3:0]                s_axi_wstrb_i,
  input  wire logic                      s_axi_wvalid_i,
  output logic                           s_axi_wready_o,
  output logic [1:0]                     s_axi_bresp_o,
  output logic                           s_axi_bvalid_o,
  input  wire logic                      s_axi_bready_i,
  input  wire logic [ddc_pkg::ADDR_W-1:0] s_axi_araddr_i,
  input  wire logic                      s_axi_arvalid_i,
  output logic                           s_axi_arready_o,
  output logic [31:0]                    s_axi_rdata_o,
  output logic [1:0]                     s_axi_rresp_o,
  output logic                           s_axi_rvalid_o,
  input  wire logic                      s_axi_rready_i
);
  localparam int NP = ddc_pkg::NUM_PATHS;
  localparam int TW = ddc_pkg::TRIG_W;
  localparam int PW = SAMPLE_W + TW;

  if (SAMPLE_W != 14 || OUT_W != 16) begin : g_chk
    $error("ddc_top: only 14-bit in, 16-bit out supported");
  end

  logic [31:0]                ctrl;
  logic [ddc_pkg::NCO_W-1:0]  nco_pend [NP];
  logic [ddc_pkg::NCO_W-1:0]  nco_act  [NP];
  logic                       mixer_restart;
  logic                       soft_align;
  logic                       align_seen;
  logic                       pin_q;
  logic                       pin_q2;
  logic                       pin_evt;
  logic                       align_evt;
  logic                       nco_load;
  logic signed [SAMPLE_W-1:0] smp;
  logic [2:0]                 dec_sel;
  logic [2:0]                 log2n;

  logic                       aw_hold;
  logic                       w_hold;
  logic [ddc_pkg::ADDR_W-1:0] aw_addr;
  logic [31:0]                w_data;
  logic [3:0]                 w_strb;
  logic                       do_write;
  logic [31:0]                rd_data;
  logic                       rd_err;
  logic                       wr_err;

  logic [OUT_W-1:0] out_i [NP];
  logic [OUT_W-1:0] out_q [NP];
  logic             out_v [NP];
  logic             out_r [NP];

  function automatic logic [31:0] wmerge(input logic [31:0] old, input logic [31:0] d, input logic [3:0] s);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (s[b]) begin
        r[8*b +: 8] = d[8*b +: 8];
      end
    end
    wmerge = r;
  endfunction

  function automatic logic signed [OUT_W-1:0] sat(input logic signed [OUT_W+1:0] v);
    logic signed [OUT_W+1:0] hi;
    logic signed [OUT_W+1:0] lo;
    hi = (OUT_W+2)'({1'b0, {(OUT_W-1){1'b1}}});
    lo = -hi - (OUT_W+2)'(1);
    if (v > hi) begin
      sat = hi[OUT_W-1:0];
    end else if (v < lo) begin
      sat = lo[OUT_W-1:0];
    end else begin
      sat = v[OUT_W-1:0];
    end
  endfunction

  // axi4-lite write: address and data taken in either order
  assign s_axi_awready_o = ~aw_hold & ~s_axi_bvalid_o;
  assign s_axi_wready_o  = ~w_hold & ~s_axi_bvalid_o;
  assign s_axi_arready_o = ~s_axi_rvalid_o;
  assign do_write        = aw_hold & w_hold & ~s_axi_bvalid_o;

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      aw_hold <= 1'b0;
      aw_addr <= '0;
    end else if (s_axi_awvalid_i && s_axi_awready_o) begin
      aw_hold <= 1'b1;
      aw_addr <= s_axi_awaddr_i;
    end else if (do_write) begin
      aw_hold <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      w_hold <= 1'b0;
      w_data <= '0;
      w_strb <= '0;
    end else if (s_axi_wvalid_i && s_axi_wready_o) begin
      w_hold <= 1'b1;
      w_data <= s_axi_wdata_i;
      w_strb <= s_axi_wstrb_i;
    end else if (do_write) begin
      w_hold <= 1'b0;
    end
  end

  always_comb begin
    wr_err = 1'b0;
    unique case (aw_addr)
      ddc_pkg::ADDR_CTRL, ddc_pkg::ADDR_NCO_A, ddc_pkg::ADDR_NCO_B,
      ddc_pkg::ADDR_RESTART, ddc_pkg::ADDR_STATUS: wr_err = 1'b0;
      default: wr_err = 1'b1;
    endcase
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      s_axi_bvalid_o <= 1'b0;
      s_axi_bresp_o  <= ddc_pkg::RESP_OKAY;
    end else if (do_write) begin
      s_axi_bvalid_o <= 1'b1;
      s_axi_bresp_o  <= wr_err ? ddc_pkg::RESP_SLVERR : ddc_pkg::RESP_OKAY;
    end else if (s_axi_bready_i) begin
      s_axi_bvalid_o <= 1'b0;
    end
  end

  // frequency words only stage here; the nco picks them up on load
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      ctrl        <= ddc_pkg::CTRL_RST;
      nco_pend[0] <= ddc_pkg::NCO_RST;
      nco_pend[1] <= ddc_pkg::NCO_RST;
    end else if (do_write) begin
      if (aw_addr == ddc_pkg::ADDR_CTRL) begin
        ctrl <= wmerge(ctrl, w_data, w_strb);
      end
      if (aw_addr == ddc_pkg::ADDR_NCO_A) begin
        nco_pend[0] <= wmerge(nco_pend[0], w_data, w_strb);
      end
      if (aw_addr == ddc_pkg::ADDR_NCO_B) begin
        nco_pend[1] <= wmerge(nco_pend[1], w_data, w_strb);
      end
    end
  end

  // restart bits are self clearing one-cycle strobes
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      mixer_restart <= 1'b0;
      soft_align    <= 1'b0;
    end else begin
      mixer_restart <= do_write && aw_addr == ddc_pkg::ADDR_RESTART
                       && w_strb[0] && w_data[ddc_pkg::RESTART_MIXER];
      soft_align    <= do_write && aw_addr == ddc_pkg::ADDR_RESTART
                       && w_strb[0] && w_data[ddc_pkg::RESTART_ALIGN];
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      pin_q       <= 1'b0;
      pin_q2      <= 1'b0;
      powerdown_o <= 1'b0;
    end else begin
      pin_q       <= powerdown_align_pin_i;
      pin_q2      <= pin_q;
      powerdown_o <= pin_q & ~ctrl[ddc_pkg::CTRL_ALIGN_PIN];
    end
  end

  assign pin_evt   = ctrl[ddc_pkg::CTRL_ALIGN_PIN] & pin_q & ~pin_q2;
  assign align_evt = pin_evt | soft_align;
  assign nco_load  = align_evt | mixer_restart;

  // set wins over a same-cycle write-one clear
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      align_seen <= 1'b0;
    end else if (align_evt) begin
      align_seen <= 1'b1;
    end else if (do_write && aw_addr == ddc_pkg::ADDR_STATUS && w_strb[0]
                 && w_data[ddc_pkg::STATUS_ALIGN_SEEN]) begin
      align_seen <= 1'b0;
    end
  end

  always_comb begin
    rd_data = '0;
    rd_err  = 1'b0;
    unique case (s_axi_araddr_i)
      ddc_pkg::ADDR_CTRL:    rd_data = ctrl;
      ddc_pkg::ADDR_NCO_A:   rd_data = nco_pend[0];
      ddc_pkg::ADDR_NCO_B:   rd_data = nco_pend[1];
      ddc_pkg::ADDR_RESTART: rd_data = '0;
      ddc_pkg::ADDR_STATUS: begin
        rd_data[ddc_pkg::STATUS_ACTIVE]     = ctrl[ddc_pkg::CTRL_EN];
        rd_data[ddc_pkg::STATUS_ALIGN_SEEN] = align_seen;
        rd_data[ddc_pkg::STATUS_PDN]        = powerdown_o;
      end
      ddc_pkg::ADDR_ACT_A:   rd_data = nco_act[0];
      ddc_pkg::ADDR_ACT_B:   rd_data = nco_act[1];
      default:               rd_err = 1'b1;
    endcase
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      s_axi_rvalid_o <= 1'b0;
      s_axi_rdata_o  <= '0;
      s_axi_rresp_o  <= ddc_pkg::RESP_OKAY;
    end else if (s_axi_arvalid_i && s_axi_arready_o) begin
      s_axi_rvalid_o <= 1'b1;
      s_axi_rdata_o  <= rd_data;
      s_axi_rresp_o  <= rd_err ? ddc_pkg::RESP_SLVERR : ddc_pkg::RESP_OKAY;
    end else if (s_axi_rready_i) begin
      s_axi_rvalid_o <= 1'b0;
    end
  end

  // out of range settings clamp to the largest factor
  assign dec_sel = ctrl[ddc_pkg::CTRL_DEC_LSB +: ddc_pkg::CTRL_DEC_W];
  assign log2n   = (dec_sel > ddc_pkg::DEC_SEL_MAX ? ddc_pkg::DEC_SEL_MAX : dec_sel) + 3'h1;

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      smp <= '0;
    end else begin
      smp <= $signed(sample_i);
    end
  end

  for (genvar p = 0; p < NP; p++) begin : g_path
    logic signed [TW-1:0]    cosv;
    logic signed [TW-1:0]    sinv;
    logic signed [PW-1:0]    prod_i;
    logic signed [PW-1:0]    prod_q;
    logic signed [OUT_W-1:0] mix_i;
    logic signed [OUT_W-1:0] mix_q;
    logic signed [OUT_W-1:0] dec_i;
    logic signed [OUT_W-1:0] dec_q;
    logic signed [OUT_W-1:0] g_i;
    logic signed [OUT_W-1:0] g_q;
    logic signed [OUT_W+9:0] r_prod;
    logic signed [OUT_W-1:0] hold;
    logic                    dec_v;
    logic                    on;
    logic                    real_m;
    logic                    fs4;
    logic                    fs4_ph;
    logic                    fs4_pend;

    assign on     = ctrl[ddc_pkg::CTRL_EN] & ((p == 0) | ctrl[ddc_pkg::CTRL_DUAL]);
    assign real_m = ctrl[ddc_pkg::CTRL_REAL];
    assign fs4    = ctrl[ddc_pkg::CTRL_FS4] & ~real_m;

    ddc_nco u_nco (
      .ref_clk_i     (ref_clk_i),
      .rst_i         (rst_i),
      .load_i        (nco_load),
      .freq_i        (nco_pend[p]),
      .cos_o         (cosv),
      .sin_o         (sinv),
      .active_freq_o (nco_act[p])
    );

    assign prod_i = smp * cosv;
    assign prod_q = smp * sinv;

    // mixer drops the two top guard bits; the table peaks just under 2^11
    always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
        mix_i <= '0;
        mix_q <= '0;
      end else if (real_m) begin
        mix_i <= OUT_W'({smp, 2'b00});
        mix_q <= '0;
      end else begin
        mix_i <= prod_i[PW-3 -: OUT_W];
        mix_q <= ctrl[ddc_pkg::CTRL_INV_LSB + p] ? -prod_q[PW-3 -: OUT_W] : prod_q[PW-3 -: OUT_W];
      end
    end

    ddc_decim u_decim (
      .ref_clk_i   (ref_clk_i),
      .rst_i       (rst_i),
      .clear_i     (align_evt),
      .log2n_i     (log2n),
      .in_i        (mix_i),
      .in_q        (mix_q),
      .out_i_o     (dec_i),
      .out_q_o     (dec_q),
      .out_valid_o (dec_v)
    );

    assign r_prod = dec_i * $signed({1'b0, ddc_pkg::REAL_GAIN_MUL});

    always_comb begin
      g_i = dec_i;
      g_q = dec_q;
      if (ctrl[ddc_pkg::CTRL_GAIN] && real_m) begin
        g_i = sat((OUT_W+2)'(r_prod >>> ddc_pkg::REAL_GAIN_SHIFT));
      end else if (ctrl[ddc_pkg::CTRL_GAIN]) begin
        g_i = sat((OUT_W+2)'(dec_i) <<< 1);
        g_q = sat((OUT_W+2)'(dec_q) <<< 1);
      end
    end

    // quarter-rate pattern I, -Q, -I, Q; second word one clock later
    always_ff @(posedge ref_clk_i) begin
      if (rst_i || align_evt) begin
        fs4_ph   <= 1'b0;
        fs4_pend <= 1'b0;
        hold     <= '0;
      end else if (on && fs4 && dec_v) begin
        fs4_pend <= 1'b1;
        hold     <= fs4_ph ? g_q : sat(-(OUT_W+2)'(g_q));
      end else if (fs4_pend) begin
        fs4_pend <= 1'b0;
        fs4_ph   <= ~fs4_ph;
      end
    end

    always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
        out_i[p] <= '0;
        out_q[p] <= '0;
        out_v[p] <= 1'b0;
        out_r[p] <= 1'b0;
      end else if (!ctrl[ddc_pkg::CTRL_EN]) begin
        out_i[p] <= {smp, 2'b00};
        out_q[p] <= '0;
        out_v[p] <= 1'b1;
        out_r[p] <= 1'b1;
      end else if (!on) begin
        out_v[p] <= 1'b0;
      end else if (fs4 && dec_v) begin
        out_i[p] <= fs4_ph ? sat(-(OUT_W+2)'(g_i)) : g_i;
        out_q[p] <= '0;
        out_v[p] <= 1'b1;
        out_r[p] <= 1'b1;
      end else if (fs4 && fs4_pend) begin
        out_i[p] <= hold;
        out_v[p] <= 1'b1;
      end else begin
        out_i[p] <= g_i;
        out_q[p] <= real_m ? '0 : g_q;
        out_v[p] <= dec_v;
        out_r[p] <= real_m;
      end
    end
  end

  assign chan_a_i_o           = out_i[0];
  assign chan_a_q_o           = out_q[0];
  assign chan_a_valid_o       = out_v[0];
  assign chan_a_real_o        = out_r[0];
  assign chan_b_lanes_i_o     = out_i[1];
  assign chan_b_lanes_q_o     = out_q[1];
  assign chan_b_lanes_valid_o = out_v[1];
  assign chan_b_lanes_real_o  = out_r[1];
endmodule
`default_nettype wire

// file: sim/ddc_core_model.sv
/*
  ddc_core_model: converter core and formatter stand-in.
  Assumes ddc_top takes one sample on every ref_clk_i edge.
*/
`timescale 1ns/1ps
`default_nettype none
module ddc_core_model (
  input  wire logic        ref_clk_i,
  input  wire logic [13:0] level_i,
  input  wire logic        sync_req_i,
  input  wire logic        clr_i,
  input  wire logic        a_valid_i,
  input  wire logic        b_valid_i,
  output logic [13:0]      sample_o,
  output logic             pin_o,
  output logic [15:0]      a_cnt_o,
  output logic [15:0]      b_cnt_o
);
  logic [5:0] ph = 6'h00;
  initial begin
    pin_o = 1'b0;
    sample_o = 14'h0000;
  end
  // strobe only on 64-cycle boundaries, else divider phase jumps
  always @(posedge ref_clk_i) begin
    ph       <= ph + 6'h01;
    sample_o <= level_i;
    pin_o    <= sync_req_i && ph == 6'h3F;
    a_cnt_o  <= clr_i ? 16'h0000 : a_cnt_o + {15'h0000, a_valid_i};
    b_cnt_o  <= clr_i ? 16'h0000 : b_cnt_o + {15'h0000, b_valid_i};
  end
endmodule
`default_nettype wire

// file: sim/ddc_top_sva.sv
/*
  ddc_sva: bus and stream checks on ddc_top ports.
  Assumes one clock domain and bind into ddc_top.
*/
`timescale 1ns/1ps
`default_nettype none
module ddc_sva (
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic powerdown_align_pin_i,
  input wire logic powerdown_o,
  input wire logic chan_a_valid_o,
  input wire logic chan_a_real_o,
  input wire logic chan_b_lanes_valid_o,
  input wire logic chan_b_lanes_real_o,
  input wire logic s_axi_awready_o,
  input wire logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  input wire logic s_axi_arvalid_i,
  input wire logic s_axi_arready_o,
  input wire logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);
  AST_BHOLD: assert property (s_axi_bvalid_o && !s_axi_bready_i |=> s_axi_bvalid_o)
    else $error("bvalid dropped");
  AST_RHOLD: assert property (s_axi_rvalid_o && !s_axi_rready_i |=> s_axi_rvalid_o)
    else $error("rvalid dropped");
  AST_RANS: assert property (s_axi_arvalid_i && s_axi_arready_o |=> s_axi_rvalid_o)
    else $error("read answer late");
  AST_ARBLK: assert property (s_axi_rvalid_o |-> !s_axi_arready_o)
    else $error("read taken while busy");
  AST_AWBLK: assert property (s_axi_bvalid_o |-> !s_axi_awready_o)
    else $error("write taken while busy");
  AST_PDN: assert property (powerdown_o |-> $past(powerdown_align_pin_i, 2))
    else $error("powerdown without pin");
  AST_APULSE: assert property (chan_a_valid_o && !chan_a_real_o |=> !(chan_a_valid_o && !chan_a_real_o))
    else $error("path a pairs too close");
  AST_BPULSE: assert property (chan_b_lanes_valid_o && !chan_b_lanes_real_o
    |=> !(chan_b_lanes_valid_o && !chan_b_lanes_real_o))
    else $error("path b pairs too close");
endmodule
bind ddc_top ddc_sva ddc_sva_i (.*);
`default_nettype wire

// file: sim/ddc_top_tb.sv
/*
  ddc_top_tb: register and stream tests of ddc_top.
  Assumes ddc_core_model as sample source and output counter.
*/
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin samples_checked++; if ((a) !== (e)) begin fail_count++; \
  $display("[ERR] t=%0t got %h exp %h", $time, a, e); end end
module ddc_top_tb;
  logic        ref_clk_i = 1'b0, rst_i = 1'b1, powerdown_align_pin_i, powerdown_o, sync_req = 1'b0, clr = 1'b0;
  logic        chan_a_valid_o, chan_a_real_o, chan_b_lanes_valid_o, chan_b_lanes_real_o;
  logic [15:0] chan_a_i_o, chan_a_q_o, chan_b_lanes_i_o, chan_b_lanes_q_o, a_cnt, b_cnt;
  logic [13:0] sample_i, level = 14'h0100;
  logic [7:0]  s_axi_awaddr_i = 8'h00, s_axi_araddr_i = 8'h00;
  logic [31:0] s_axi_wdata_i = 32'h0000_0000, s_axi_rdata_o, rv;
  logic [3:0]  s_axi_wstrb_i = 4'hF;
  logic [1:0]  s_axi_bresp_o, s_axi_rresp_o, rs;
  logic        s_axi_awvalid_i = 1'b0, s_axi_wvalid_i = 1'b0, s_axi_bready_i = 1'b0, s_axi_arvalid_i = 1'b0;
  logic        s_axi_rready_i = 1'b0, s_axi_awready_o, s_axi_wready_o, s_axi_bvalid_o, s_axi_arready_o, s_axi_rvalid_o;
  int          fail_count = 0, samples_checked = 0;
  logic [31:0] ctl [8] = '{32'h0000_0081, 32'h0000_0085, 32'h0000_0089, 32'h0000_008D,
                           32'h0000_0091, 32'h0000_0087, 32'h0000_00C5, 32'h0000_0005};
  int          ea [8] = '{32, 16, 8, 4, 2, 16, 32, 16};
  int          eb [8] = '{32, 16, 8, 4, 2, 16, 32, 0};
  ddc_top ddc_top_i (.*);
  ddc_core_model ddc_core_model_i (.ref_clk_i(ref_clk_i), .level_i(level), .sync_req_i(sync_req), .clr_i(clr),
    .a_valid_i(chan_a_valid_o), .b_valid_i(chan_b_lanes_valid_o), .sample_o(sample_i),
    .pin_o(powerdown_align_pin_i), .a_cnt_o(a_cnt), .b_cnt_o(b_cnt));
  always #20 ref_clk_i = ~ref_clk_i;
  task automatic conclude();
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic tmo(input int k);
    if (k >= 20) begin
      fail_count++;
      conclude();
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic ad, dd;
    int k;
    ad = 1'b1;
    dd = 1'b1;
    @(posedge ref_clk_i);
    s_axi_awaddr_i  <= a;
    s_axi_wdata_i   <= d;
    s_axi_awvalid_i <= 1'b1;
    s_axi_wvalid_i  <= 1'b1;
    s_axi_bready_i  <= 1'b1;
    for (k = 0; k < 20 && (ad || dd || !s_axi_bvalid_o); k++) begin
      @(posedge ref_clk_i);
      if (s_axi_awready_o) ad = 1'b0;
      if (s_axi_wready_o) dd = 1'b0;
      s_axi_awvalid_i <= ad;
      s_axi_wvalid_i  <= dd;
    end
    s_axi_bready_i <= 1'b0;
    tmo(k);
  endtask
  task automatic rd(input logic [7:0] a);
    logic av;
    int k;
    av = 1'b1;
    @(posedge ref_clk_i);
    s_axi_araddr_i  <= a;
    s_axi_arvalid_i <= 1'b1;
    s_axi_rready_i  <= 1'b1;
    for (k = 0; k < 20 && (av || !s_axi_rvalid_o); k++) begin
      @(posedge ref_clk_i);
      if (s_axi_arready_o) av = 1'b0;
      s_axi_arvalid_i <= av;
    end
    rv = s_axi_rdata_o;
    rs = s_axi_rresp_o;
    s_axi_rready_i <= 1'b0;
    tmo(k);
  endtask
  task automatic pulse();
    @(posedge ref_clk_i);
    sync_req <= 1'b1;
    repeat (64) @(posedge ref_clk_i);
    sync_req <= 1'b0;
    repeat (4) @(posedge ref_clk_i);
  endtask
  task automatic vout(input logic [32:0] e);
    int k;
    repeat (12) @(posedge ref_clk_i);
    for (k = 0; k < 20 && chan_a_valid_o !== 1'b1; k++) @(posedge ref_clk_i);
    tmo(k);
    `CHK({chan_a_real_o, chan_a_q_o, chan_a_i_o}, e)
  endtask
  initial begin
    repeat (2) @(posedge ref_clk_i);
    rst_i <= 1'b0;
    repeat (4) @(posedge ref_clk_i);
    #1;
    `CHK(chan_a_i_o, {level, 2'b00})
    `CHK({chan_b_lanes_i_o, chan_a_valid_o, chan_a_real_o}, {level, 2'b00, 2'b11})
    rd(ddc_pkg::ADDR_CTRL);
    `CHK(rv, ddc_pkg::CTRL_RST)
    rd(8'h1C);
    `CHK({rs, rv}, {ddc_pkg::RESP_SLVERR, 32'h0000_0000})
    $display("test bypass done");
    wr(ddc_pkg::ADDR_NCO_A, 32'h147A_E148);
    rd(ddc_pkg::ADDR_ACT_A);
    `CHK(rv, ddc_pkg::NCO_RST)
    wr(ddc_pkg::ADDR_RESTART, 32'h0000_0001);
    rd(ddc_pkg::ADDR_ACT_A);
    `CHK(rv, 32'h147A_E148)
    wr(ddc_pkg::ADDR_NCO_A, 32'hEB85_1EB8);
    wr(ddc_pkg::ADDR_RESTART, 32'h0000_0002);
    rd(ddc_pkg::ADDR_ACT_A);
    `CHK(rv, 32'hEB85_1EB8)
    wr(ddc_pkg::ADDR_NCO_B, 32'h147A_E148);
    pulse();
    rd(ddc_pkg::ADDR_ACT_B);
    `CHK(rv, ddc_pkg::NCO_RST)
    wr(ddc_pkg::ADDR_CTRL, 32'h0000_0400);
    pulse();
    rd(ddc_pkg::ADDR_ACT_B);
    `CHK(rv, 32'h147A_E148)
    rd(ddc_pkg::ADDR_STATUS);
    `CHK(rv[2:0], 3'h2)
    wr(ddc_pkg::ADDR_STATUS, 32'h0000_0002);
    rd(ddc_pkg::ADDR_STATUS);
    `CHK(rv[2:0], 3'h0)
    $display("test oscillator done");
    for (int i = 0; i < 8; i++) begin
      wr(ddc_pkg::ADDR_CTRL, ctl[i]);
      wr(ddc_pkg::ADDR_RESTART, 32'h0000_0002);
      repeat (8) @(posedge ref_clk_i);
      clr <= 1'b1;
      @(posedge ref_clk_i);
      clr <= 1'b0;
      repeat (64) @(posedge ref_clk_i);
      #1;
      `CHK(a_cnt, 16'(ea[i]))
      `CHK(b_cnt, 16'(eb[i]))
    end
    $display("test rates done");
    wr(ddc_pkg::ADDR_CTRL, 32'h0000_0007);
    vout({1'b1, 16'h0000, 16'h0400});
    wr(ddc_pkg::ADDR_CTRL, 32'h0000_0027);
    vout({1'b1, 16'h0000, 16'h05A8});
    wr(ddc_pkg::ADDR_NCO_A, 32'h0000_0000);
    wr(ddc_pkg::ADDR_RESTART, 32'h0000_0001);
    wr(ddc_pkg::ADDR_CTRL, 32'h0000_0125);
    vout({1'b0, 16'hFF9C, 16'h07FC});
    $display("test gain done");
    conclude();
  end
endmodule
`default_nettype wire
